//--- eeprom_pe_regs.vh
// register offsets, field positions, reset values and timing for the eeprom
// program/erase controller; included by the controller, the checker and the bench
`ifndef EEPROM_PE_REGS_VH
`define EEPROM_PE_REGS_VH

// ****************************************
// bus register offsets (byte addresses)
// ****************************************
`define OFS_CONTROL      12'h000
`define OFS_ARRAY_CONFIG 12'h004
`define OFS_NV_OPTIONS   12'h008
`define OFS_STATUS       12'h00c
`define OFS_ARRAY_BASE   12'h800
`define ARRAY_DEPTH      512
`define ARRAY_AW         9
`define NV_INDEX         9'h000

// ****************************************
// control register fields
// ****************************************
`define CTL_SPARE        7
`define CTL_POWER_DOWN   6
`define CTL_MODE_HI      4
`define CTL_MODE_LO      3
`define CTL_LATCH        2
`define CTL_AUTO         1
`define CTL_PGM          0
`define CTL_RESET        8'h00

// ****************************************
// array config fields and modes
// ****************************************
`define CFG_PROT_EN      4
`define CFG_BP_MSB       3
`define NV_FACTORY       8'hf0
`define ERASED_BYTE      8'hff
`define MODE_BYTE_PGM    2'b00
`define MODE_BYTE_ERASE  2'b01
`define MODE_BLOCK_ERASE 2'b10
`define MODE_BULK_ERASE  2'b11
`define SECURE_BLOCK     2'b01
`define SECURE_TOP       3'b111

// ****************************************
// bus responses
// ****************************************
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

// ****************************************
// auto termination timing
// ****************************************
`define AUTO_TIME_NS     50000
`define CLOCK_NS         10
`define AUTO_CYCLES      (`AUTO_TIME_NS / `CLOCK_NS)
`define TIMER_W          16

`endif

//--- eeprom_cell_array.v
// 512-byte nonvolatile cell array model as a synchronous memory
// assumes one access per cycle; read data are registered
module eeprom_cell_array
(
  input  wire       i_clock,
  input  wire       i_we,
  input  wire [8:0] i_addr,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_rdata
);
  reg [7:0] mem [0:511];
  integer   k;

  initial
  begin
    for (k = 0; k < 512; k = k + 1)
      mem[k] = 8'hff;
  end

  always @(posedge i_clock)
  begin
    if (i_we)
      mem[i_addr] <= i_wdata;
    o_rdata <= mem[i_addr];
  end
endmodule // eeprom_cell_array

//--- eeprom_erase_program_control.v
// eeprom program/erase sequencer with axi4-lite register and array window
// assumes a single clock; array behind eeprom_cell_array; nv options held in flops
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`include "eeprom_pe_regs.vh"
module eeprom_erase_program_control
(
  input  wire        i_clock,
  input  wire        i_rstn,
  input  wire [11:0] i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [11:0] i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  output wire        o_pump_on
);
  // ****************************************
  // state
  // ****************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_RDWAIT = 2'b01;
  localparam ST_RDDONE = 2'b10;

  reg [7:0]          control_q;
  reg [7:0]          config_q;
  reg [7:0]          nv_q;
  reg                aw_full_q;
  reg                w_full_q;
  reg [11:0]         awaddr_q;
  reg [31:0]         wdata_q;
  reg [3:0]          wstrb_q;
  reg [`ARRAY_AW-1:0] tgt_addr_q;
  reg [7:0]          tgt_data_q;
  reg                tgt_valid_q;
  reg                cycle_fail_q;
  reg                op_done_q;
  reg [`TIMER_W-1:0] timer_q;
  reg [1:0]          rd_state_q;
  reg [11:0]         araddr_q;
  reg                cfg_loaded_q;

  wire [7:0]         mem_rdata;
  reg                mem_we;
  reg [`ARRAY_AW-1:0] mem_addr;
  reg [7:0]          mem_wdata;

  // ****************************************
  // write channel capture
  // ****************************************
  assign o_awready = !aw_full_q;
  assign o_wready  = !w_full_q;
  assign o_arready = (rd_state_q == ST_IDLE) && !o_rvalid;
  assign o_pump_on = control_q[`CTL_PGM];

  wire do_write = aw_full_q && w_full_q && !o_bvalid;
  wire wr_array = (awaddr_q >= `OFS_ARRAY_BASE)
                  && (awaddr_q < `OFS_ARRAY_BASE + `ARRAY_DEPTH);
  wire [`ARRAY_AW-1:0] wr_idx = awaddr_q[`ARRAY_AW-1:0];
  wire rd_array = (araddr_q >= `OFS_ARRAY_BASE)
                  && (araddr_q < `OFS_ARRAY_BASE + `ARRAY_DEPTH);

  wire latch   = control_q[`CTL_LATCH];
  wire pgm     = control_q[`CTL_PGM];
  wire prot_en = !config_q[`CFG_PROT_EN];
  wire [1:0] mode = control_q[`CTL_MODE_HI:`CTL_MODE_LO];
  wire [7:0] wbyte = wdata_q[7:0];

  // ****************************************
  // per-byte protection
  // ****************************************
  function allowed;
    input [`ARRAY_AW-1:0] a;
    input [7:0]           cfg;
    input [1:0]           m;
    input                 sec;
    begin
      allowed = !cfg[a[8:7]];
      if (sec && (m == `MODE_BLOCK_ERASE || m == `MODE_BULK_ERASE))
        allowed = 1'b0;
      if (sec && a[8:7] == `SECURE_BLOCK && a[6:4] == `SECURE_TOP)
        allowed = 1'b0;
    end
  endfunction

  // target of current operation; nv register when the target write went to the nv options offset
  reg                tgt_is_nv_q;
  wire nv_ok = !prot_en;

  // ****************************************
  // operation sweep counter for block/bulk erase
  // ****************************************
  reg [`ARRAY_AW-1:0] sweep_q;
  reg                sweep_on_q;

  always @*
  begin
    mem_we = 1'b0;
    // target preread while pumping, so a program merges with the stored byte
    mem_addr = pgm ? tgt_addr_q : araddr_q[`ARRAY_AW-1:0];
    mem_wdata = `ERASED_BYTE;
    if (sweep_on_q)
    begin
      mem_addr = sweep_q;
      mem_we = allowed(sweep_q, config_q, mode, prot_en);
    end
    else if (op_done_q && !cycle_fail_q && !tgt_is_nv_q)
    begin
      mem_addr = tgt_addr_q;
      if (mode == `MODE_BYTE_PGM)
      begin
        mem_we = allowed(tgt_addr_q, config_q, mode, prot_en);
        mem_wdata = mem_rdata & tgt_data_q;
      end
      else if (mode == `MODE_BYTE_ERASE)
        mem_we = allowed(tgt_addr_q, config_q, mode, prot_en);
    end
  end

  eeprom_cell_array u_cells
  (
    .i_clock (i_clock),
    .i_we    (mem_we),
    .i_addr  (mem_addr),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  // ****************************************
  // bus, control and sequencing
  // ****************************************
  wire wr_ctl = do_write && awaddr_q == `OFS_CONTROL && wstrb_q[0];
  wire timer_end = pgm && control_q[`CTL_AUTO] && timer_q == `AUTO_CYCLES - 1;
  wire rd_take = i_arvalid && o_arready;

  always @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      control_q <= `CTL_RESET;
      config_q <= `NV_FACTORY;
      nv_q <= `NV_FACTORY;
      cfg_loaded_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
      tgt_addr_q <= {`ARRAY_AW{1'b0}};
      tgt_data_q <= 8'h00;
      tgt_valid_q <= 1'b0;
      tgt_is_nv_q <= 1'b0;
      cycle_fail_q <= 1'b0;
      op_done_q <= 1'b0;
      timer_q <= {`TIMER_W{1'b0}};
      sweep_q <= {`ARRAY_AW{1'b0}};
      sweep_on_q <= 1'b0;
      rd_state_q <= ST_IDLE;
      araddr_q <= 12'h000;
      o_rvalid <= 1'b0;
      o_rresp <= `RESP_OKAY;
      o_rdata <= 32'h00000000;
    end
    else
    begin
      if (!cfg_loaded_q)
      begin
        config_q <= nv_q;
        cfg_loaded_q <= 1'b1;
      end
      if (i_awvalid && o_awready)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        w_full_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
      op_done_q <= 1'b0;
      if (sweep_on_q)
      begin
        sweep_q <= sweep_q + 1'b1;
        if (sweep_q == `ARRAY_DEPTH - 1 || (mode == `MODE_BLOCK_ERASE && sweep_q[6:0] == 7'h7f))
          sweep_on_q <= 1'b0;
      end
      if (pgm)
        timer_q <= timer_q + 1'b1;
      if (timer_end)
        control_q[`CTL_PGM] <= 1'b0;

      // pgm falling: commit the operation
      if ((timer_end || (wr_ctl && !wbyte[`CTL_PGM] && pgm)) && !cycle_fail_q)
      begin
        if (tgt_is_nv_q && nv_ok)
          nv_q <= (mode == `MODE_BYTE_PGM) ? (nv_q & tgt_data_q) : `ERASED_BYTE;
        else if (!tgt_is_nv_q && (mode == `MODE_BLOCK_ERASE || mode == `MODE_BULK_ERASE))
        begin
          sweep_on_q <= 1'b1;
          sweep_q <= (mode == `MODE_BULK_ERASE) ? {`ARRAY_AW{1'b0}} : {tgt_addr_q[8:7], 7'h00};
        end
        else
          op_done_q <= 1'b1;
      end

      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= `RESP_OKAY;
        if (wr_ctl)
        begin
          if (!latch || tgt_valid_q || pgm)
          begin
            control_q[`CTL_SPARE] <= wbyte[`CTL_SPARE];
            control_q[`CTL_POWER_DOWN] <= wbyte[`CTL_POWER_DOWN];
            control_q[`CTL_MODE_HI:`CTL_AUTO] <= wbyte[`CTL_MODE_HI:`CTL_AUTO];
            if (!wbyte[`CTL_LATCH] && (pgm || (!latch && 1'b0)))
              control_q[`CTL_LATCH] <= 1'b1;
            if (wbyte[`CTL_PGM] && !pgm)
            begin
              if (latch && tgt_valid_q)
              begin
                control_q[`CTL_PGM] <= 1'b1;
                timer_q <= {`TIMER_W{1'b0}};
                cycle_fail_q <= 1'b0;
              end
            end
            else if (!wbyte[`CTL_PGM])
              control_q[`CTL_PGM] <= 1'b0;
            if (!wbyte[`CTL_LATCH] && !pgm)
              tgt_valid_q <= 1'b0;
          end
        end
        else if (awaddr_q == `OFS_NV_OPTIONS && latch && !pgm)
        begin
          tgt_is_nv_q <= 1'b1;
          tgt_data_q <= wbyte;
          tgt_valid_q <= 1'b1;
        end
        else if (wr_array && latch && !pgm && !control_q[`CTL_POWER_DOWN])
        begin
          tgt_addr_q <= wr_idx;
          tgt_data_q <= wbyte;
          tgt_valid_q <= 1'b1;
          tgt_is_nv_q <= 1'b0;
        end
        else if (!(awaddr_q == `OFS_ARRAY_CONFIG || awaddr_q == `OFS_NV_OPTIONS || wr_array))
          o_bresp <= `RESP_SLVERR;
      end

      // read path
      if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
      case (rd_state_q)
        ST_IDLE:
        begin
          if (rd_take)
          begin
            araddr_q <= i_araddr;
            rd_state_q <= ST_RDWAIT;
          end
        end
        ST_RDWAIT:
        begin
          rd_state_q <= ST_RDDONE;
        end
        ST_RDDONE:
        begin
          rd_state_q <= ST_IDLE;
          o_rvalid <= 1'b1;
          o_rresp <= `RESP_OKAY;
          o_rdata <= 32'h00000000;
          if (rd_array)
          begin
            if (pgm)
              cycle_fail_q <= 1'b1;
            if (latch && !pgm)
            begin
              o_rdata[7:0] <= tgt_data_q;
              tgt_addr_q <= araddr_q[`ARRAY_AW-1:0];
              tgt_is_nv_q <= 1'b0;
            end
            else if (control_q[`CTL_POWER_DOWN])
              o_rdata[7:0] <= `ERASED_BYTE;
            else
              o_rdata[7:0] <= mem_rdata;
          end
          else if (araddr_q == `OFS_CONTROL)
            o_rdata[7:0] <= control_q;
          else if (araddr_q == `OFS_ARRAY_CONFIG)
            o_rdata[7:0] <= config_q;
          else if (araddr_q == `OFS_NV_OPTIONS)
          begin
            o_rdata[7:0] <= nv_q;
            config_q[`CFG_BP_MSB:0] <= nv_q[`CFG_BP_MSB:0];
            if (nv_ok)
              config_q[`CFG_PROT_EN] <= nv_q[`CFG_PROT_EN];
          end
          else if (araddr_q == `OFS_STATUS)
            o_rdata[2:0] <= {sweep_on_q, cycle_fail_q, tgt_valid_q};
          else
            o_rresp <= `RESP_SLVERR;
        end
        default:
        begin
          rd_state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // eeprom_erase_program_control

//--- eeprom_pe_checker.sv
// checker: bus handshakes, read latency and pump start of the eeprom controller
// assumes the design header macros and a single clock domain
`include "eeprom_pe_regs.vh"
module eeprom_pe_checker
(
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic        o_pump_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence read_taken;
    i_arvalid && o_arready;
  endsequence
  sequence read_answer;
    ##[3:4] o_rvalid;
  endsequence
  bvalid_holds_a: assert property (o_bvalid && !i_bready |=> o_bvalid) else $error("bvalid dropped early");
  rvalid_holds_a: assert property (o_rvalid && !i_rready |=> o_rvalid) else $error("rvalid dropped early");
  rdata_steady_a: assert property (o_rvalid && !i_rready |=> $stable(o_rdata)) else $error("read data moved");
  read_latency_a: assert property (read_taken |-> read_answer) else $error("read answer late");
  read_busy_a: assert property (o_rvalid |-> !o_arready) else $error("read taken while answer pending");
  write_latency_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write answer late");
  bresp_code_a: assert property (o_bvalid |-> o_bresp == `RESP_OKAY || o_bresp == `RESP_SLVERR)
    else $error("bad write response code");
  reset_quiet_a: assert property ($rose(i_rstn) |-> !o_pump_on && !o_bvalid && !o_rvalid)
    else $error("outputs busy after reset");
  pump_cause_a: assert property ($rose(o_pump_on) |-> $past(i_wvalid) || $past(i_wvalid, 2)
    || $past(i_wvalid, 3)) else $error("pump rose without a write");
endmodule // eeprom_pe_checker

bind eeprom_erase_program_control eeprom_pe_checker chk (.i_clock(i_clock), .i_rstn(i_rstn),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_pump_on(o_pump_on));

//--- eeprom_bus_master.sv
// cpu side axi4-lite master: one write or one read at a time
// assumes requests start after a rising edge; o_hung flags a lost answer
module eeprom_bus_master
(
  input  wire logic        i_clock,
  output logic [11:0]      o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_wstrb,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  output logic [11:0]      o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready,
  output logic             o_hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready, o_araddr, o_arvalid, o_rready, o_hung} = '0;
    o_wstrb = 4'hf;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clock);
    o_awaddr <= a;
    o_wdata <= d;
    o_awvalid <= 1'b1;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge i_clock);
      if (o_awvalid && i_awready) o_awvalid <= 1'b0;
      if (o_wvalid && i_wready) o_wvalid <= 1'b0;
      if (i_bvalid) break;
    end
    r = i_bresp;
    o_bready <= 1'b0;
    if (n == 200) o_hung <= 1'b1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clock);
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge i_clock);
      if (o_arvalid && i_arready) o_arvalid <= 1'b0;
      if (i_rvalid) break;
    end
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
    if (n == 200) o_hung <= 1'b1;
  endtask
endmodule // eeprom_bus_master

//--- eeprom_erase_program_control_tb.sv
// bench: program, erase and protection sequences through the register bus
// assumes the design header macros and the bus master model
`include "eeprom_pe_regs.vh"
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %0t %s", $time, msg); end end
module eeprom_erase_program_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pump, hung;
  logic [31:0] d;
  int          errors = 0;
  int          n_checks = 0;
  always #5 clock = ~clock;
  eeprom_erase_program_control DUT (.i_clock(clock), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_pump_on(pump));
  eeprom_bus_master bus (.i_clock(clock), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
    .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp),
    .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready),
    .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready), .o_hung(hung));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge hung)
  begin
    errors++;
    end_of_test();
  end
  task automatic w(input logic [11:0] a, input logic [7:0] v);
    bus.wr(a, {24'h0, v}, r);
    `CHK(r, `RESP_OKAY, "write refused")
  endtask
  task automatic ck(input logic [11:0] a, input logic [7:0] e, input string m);
    bus.rd(a, d, r);
    `CHK({r, d[7:0]}, {`RESP_OKAY, e}, m)
  endtask
  // read until the chosen bit drops
  task automatic poll(input logic [11:0] a, input int b);
    int n;
    for (n = 0; n < 3000; n++)
    begin
      bus.rd(a, d, r);
      if (d[b] === 1'b0) break;
    end
    if (n == 3000)
    begin
      errors++;
      end_of_test();
    end
  endtask
  // manual cycle: latch, target, pump on, pump off, wait sweep, unlatch
  task automatic op(input logic [7:0] m, input logic [11:0] a, input logic [7:0] v);
    w(`OFS_CONTROL, m | 8'h04);
    w(a, v);
    w(`OFS_CONTROL, m | 8'h05);
    w(`OFS_CONTROL, m | 8'h04);
    poll(`OFS_STATUS, 2);
    w(`OFS_CONTROL, 8'h00);
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    ck(`OFS_CONTROL, `CTL_RESET, "control reset");
    ck(`OFS_NV_OPTIONS, `NV_FACTORY, "nv factory value");
    bus.rd(`OFS_ARRAY_CONFIG, d, r);
    `CHK(d[4:0], 5'h10, "config loaded")
    bus.rd(12'h010, d, r);
    `CHK(r, `RESP_SLVERR, "unmapped read")
    $display("test reset done");
    w(`OFS_CONTROL, 8'h04);
    w(`OFS_CONTROL, 8'h05);
    ck(`OFS_CONTROL, 8'h04, "control taken before target");
    `CHK(pump, 1'b0, "pump without target")
    w(12'h810, 8'ha5);
    w(12'h814, 8'h3c);
    ck(12'h810, 8'h3c, "latched read data");
    w(`OFS_CONTROL, 8'h05);
    `CHK(pump, 1'b1, "pump on")
    w(`OFS_CONTROL, 8'h01);
    ck(`OFS_CONTROL, 8'h05, "latch cleared under pump");
    w(`OFS_CONTROL, 8'h00);
    ck(`OFS_CONTROL, 8'h04, "double clear");
    `CHK(pump, 1'b0, "pump off")
    poll(`OFS_STATUS, 2);
    w(`OFS_CONTROL, 8'h00);
    ck(12'h810, 8'h3c, "read address became target");
    ck(12'h814, 8'hff, "older target dropped");
    $display("test latch done");
    w(`OFS_CONTROL, 8'h0e);
    w(12'h810, 8'h00);
    w(`OFS_CONTROL, 8'h0f);
    poll(`OFS_CONTROL, 0);
    w(`OFS_CONTROL, 8'h00);
    ck(12'h810, `ERASED_BYTE, "auto byte erase");
    $display("test auto done");
    op(8'h00, 12'h900, 8'h00);
    op(8'h00, 12'h980, 8'h00);
    op(8'h10, 12'h904, 8'h55);
    ck(12'h900, `ERASED_BYTE, "block erase");
    ck(12'h980, 8'h00, "other block kept");
    op(8'h18, 12'h800, 8'h55);
    ck(12'h980, `ERASED_BYTE, "bulk erase");
    $display("test modes done");
    w(`OFS_CONTROL, 8'h04);
    w(12'h830, 8'h00);
    w(`OFS_CONTROL, 8'h05);
    bus.rd(12'h830, d, r);
    w(`OFS_CONTROL, 8'h04);
    ck(`OFS_STATUS, 8'h03, "cycle failed flag");
    w(`OFS_CONTROL, 8'h00);
    ck(12'h830, `ERASED_BYTE, "failed cycle kept byte");
    $display("test fail done");
    op(8'h00, 12'h820, 8'h00);
    w(`OFS_CONTROL, 8'hc0);
    ck(`OFS_CONTROL, 8'hc0, "spare bit stored");
    ck(12'h820, `ERASED_BYTE, "powered down read");
    w(`OFS_CONTROL, 8'h00);
    ck(12'h820, 8'h00, "powered up read");
    op(8'h08, 12'h008, 8'h00);
    ck(`OFS_NV_OPTIONS, 8'hff, "nv erased");
    bus.rd(`OFS_ARRAY_CONFIG, d, r);
    `CHK(d[4:0], 5'h1f, "protect reloaded")
    op(8'h00, 12'h840, 8'h00);
    ck(12'h840, `ERASED_BYTE, "protected block");
    $display("test protect done");
    op(8'h00, 12'h008, 8'he0);
    ck(`OFS_NV_OPTIONS, 8'he0, "nv programmed");
    op(8'h00, 12'h8f0, 8'h00);
    ck(12'h8f0, `ERASED_BYTE, "secured range");
    op(8'h00, 12'h800, 8'h00);
    ck(12'h800, 8'h00, "secure byte program");
    op(8'h10, 12'h800, 8'h55);
    ck(12'h800, 8'h00, "secure block erase refused");
    op(8'h08, 12'h008, 8'h00);
    ck(`OFS_NV_OPTIONS, 8'he0, "nv locked");
    $display("test security done");
    end_of_test();
  end
endmodule // eeprom_erase_program_control_tb
